// ---- sleep_seq_pkg.sv ----
// Constants, types and pin bundle for the regulator sleep-mode sequencer.
// Assumes one 125 MHz system clock and pins that arrive asynchronously.
// Overview of operation
// [R1] Deep sleep adds offset to VID setpoint
// [R2] Driver disable falls 32 ticks after deep-sleep
// [R3] Skip mode starts 30 ticks after disable
// [R4] Deep-sleep exit: PWM, enable drivers, drop offset
// [R5] Deep-sleep edge forces good, clock on 32 ticks
// [R6] Suspend request slews setpoint to suspend code
// [R7] Suspend: disable 32 ticks after final code
// [R8] Suspend: skip mode 30 ticks after disable
// [R9] Suspend exit: PWM, enable drivers, slew up
// [R10] Suspend edges blank good fall, clock gating
// [R11] Slave gates stay low while disabled
// [R12] Skip mode: zero crossing ends low gate
// [R13] Over-limit valley current blocks new cycle
// [R14] High gate waits for low gate off
// [R15] Low gate waits 35ns after high off
// [R16] Forced PWM: low gate complements high gate
// [R17] On-time fires on three conditions only
// [R18] New mode edge restarts pending delay counts
package sleep_seq_pkg;
   localparam int VID_W          = 6;
   localparam int SUS_W          = 3;
   localparam int OFS_W          = 4;
   localparam int SP_W           = 8;
   localparam int CNT_W          = 6;
   localparam logic [CNT_W-1:0] DLY_DDO   = 6'h20;   // Ticks before driver disable
   localparam logic [CNT_W-1:0] DLY_SKIP  = 6'h1e;   // Ticks before skip mode
   localparam logic [CNT_W-1:0] DLY_BLANK = 6'h20;   // Ticks of force and blank
   localparam logic [SP_W-1:0]  SUS_BASE  = 8'h10;   // Setpoint of suspend code zero
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int DEAD_TIME_NS   = 35;
   // Least time, so round up
   localparam int DEAD_CYC_I     = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [2:0] DEAD_CYC = 3'(DEAD_CYC_I);

   // Pins from outside the clock domain, synchronised as one bundle
   typedef struct packed {
      logic             deep_sleep_n;
      logic             suspend_req;
      logic             slew_tick;
      logic             err_low;       // Error comparator low
      logic             over_limit;    // Valley current above limit
      logic             min_off_done;
      logic             on_time_done;
      logic             zero_cross;
      logic             low_off_fb;    // Low gate seen fully off
      logic [VID_W-1:0] vid_code;
      logic [SUS_W-1:0] suspend_code;
      logic [OFS_W-1:0] offset_plus;
      logic [OFS_W-1:0] offset_minus;
   } pins_t;

   // Idle pin levels; the synchroniser resets here so no false mode edge follows reset
   localparam pins_t PINS_IDLE = '{deep_sleep_n: 1'b1, default: '0};

   typedef struct packed {
      logic high_gate;
      logic low_gate;
   } gates_t;

   typedef enum logic [2:0] {
      ST_RUN      = 3'b000,
      ST_DS_WAIT  = 3'b001,
      ST_DS_SKW   = 3'b010,
      ST_DS_SKIP  = 3'b011,
      ST_SUS_SLEW = 3'b100,
      ST_SUS_WAIT = 3'b101,
      ST_SUS_SKW  = 3'b110,
      ST_SUS_SKIP = 3'b111
   } seq_state_t;

   typedef enum logic [1:0] {
      G_IDLE  = 2'b00,
      G_LOW   = 2'b01,
      G_HIGH  = 2'b10,
      G_DEAD  = 2'b11
   } gate_state_t;
endpackage : sleep_seq_pkg

// ---- sleep_seq.sv ----
// Sleep and suspend mode sequencer with gate-drive timing of the regulator.
// Assumes mode and comparator pins are asynchronous; raw power-good and
// clock-gate levels come from logic on clk_sys.
`timescale 1ns/100ps
module sleep_seq (
   input  wire logic                        clk_sys,
   input  wire logic                        arst_n,
   input  wire logic                        clk_en,
   input  wire sleep_seq_pkg::pins_t        pins,
   input  wire logic                        pwr_good_raw,
   input  wire logic                        clk_gate_raw_n,
   output logic                             driver_disable_n,
   output logic                             skip_mode,
   output logic                             vcore_good,
   output logic                             cpu_clk_gate_n,
   output logic [sleep_seq_pkg::SP_W-1:0]   setpoint,
   output sleep_seq_pkg::gates_t            gates
);
   import sleep_seq_pkg::*;

   pins_t           s1_r, s2_r;
   logic            ds_q_r, sus_q_r, tick_q_r;
   seq_state_t      st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt, force_r, blank_cnt_r;
   logic            blank_r;
   logic [SP_W-1:0] dac_r;
   gate_state_t     g_r, g_nxt;
   logic [2:0]      dead_r;
   logic            vg_r, cg_r;

   // Two-stage synchroniser; only the second stage feeds logic
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_r <= PINS_IDLE;
         s2_r <= PINS_IDLE;
      end
      else if (clk_en)
      begin
         s1_r <= pins;
         s2_r <= s1_r;
      end
   end

   // Edge detection on synchronised levels
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ds_q_r   <= 1'b1;
         sus_q_r  <= 1'b0;
         tick_q_r <= 1'b0;
      end
      else if (clk_en)
      begin
         ds_q_r   <= s2_r.deep_sleep_n;
         sus_q_r  <= s2_r.suspend_req;
         tick_q_r <= s2_r.slew_tick;
      end
   end

   wire ds_fall  = ds_q_r & ~s2_r.deep_sleep_n;
   wire ds_rise  = ~ds_q_r & s2_r.deep_sleep_n;
   wire sus_rise = ~sus_q_r & s2_r.suspend_req;
   wire sus_fall = sus_q_r & ~s2_r.suspend_req;
   wire tick     = ~tick_q_r & s2_r.slew_tick;
   wire mode_edge = ds_fall | ds_rise | sus_rise | sus_fall;

   // Target code: suspend code, VID plus offset in deep sleep, else VID
   wire        in_sus   = st_r[2];
   wire        in_ds    = ~st_r[2] & (st_r != ST_RUN);
   wire [SP_W:0] ofs_sum = {3'h0, s2_r.vid_code} + {5'h00, s2_r.offset_plus}
                           - {5'h00, s2_r.offset_minus};
   wire [SP_W-1:0] ofs_tgt = ofs_sum[SP_W] ? '0 : ofs_sum[SP_W-1:0];          // [R1]
   wire [SP_W-1:0] sus_tgt = SUS_BASE + {5'h00, s2_r.suspend_code};           // [R6]
   wire [SP_W-1:0] vid_tgt = {2'h0, s2_r.vid_code};                           // [R4] [R9]
   wire [SP_W-1:0] target  = in_sus ? sus_tgt : (in_ds ? ofs_tgt : vid_tgt);
   wire            at_tgt  = (dac_r == target);
   wire [SP_W-1:0] dac_nxt = (dac_r < target) ? dac_r + 8'h01 : dac_r - 8'h01;

   // Slew one code per tick toward the target
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         dac_r <= '0;
      else if (clk_en && tick && !at_tgt)
         dac_r <= dac_nxt;
   end
   assign setpoint = dac_r;

   // Mode sequencer; suspend outranks deep sleep
   wire cnt_hit_ddo  = tick && (cnt_r == DLY_DDO - 6'h01);
   wire cnt_hit_skip = tick && (cnt_r == DLY_SKIP - 6'h01);
   always_comb
   begin
      st_nxt  = st_r;
      cnt_nxt = tick ? cnt_r + 6'h01 : cnt_r;
      if (sus_rise)
      begin
         st_nxt  = ST_SUS_SLEW;                                               // [R6]
         cnt_nxt = '0;                                                        // [R18]
      end
      else if (sus_fall)
      begin
         st_nxt  = s2_r.deep_sleep_n ? ST_RUN : ST_DS_WAIT;                   // [R9]
         cnt_nxt = '0;                                                        // [R18]
      end
      else if (ds_fall && !in_sus)
      begin
         st_nxt  = ST_DS_WAIT;                                                // [R1]
         cnt_nxt = '0;                                                        // [R18]
      end
      else if (ds_rise && !in_sus)
      begin
         st_nxt  = ST_RUN;                                                    // [R4]
         cnt_nxt = '0;
      end
      else
      begin
         unique case (st_r)
            ST_RUN, ST_DS_SKIP, ST_SUS_SKIP:
               cnt_nxt = '0;
            ST_DS_WAIT:
               if (cnt_hit_ddo)
                  st_nxt = ST_DS_SKW;                                         // [R2]
            ST_DS_SKW:
               if (cnt_hit_skip)
                  st_nxt = ST_DS_SKIP;                                        // [R3]
            ST_SUS_SLEW:
            begin
               cnt_nxt = '0;
               if (at_tgt)
                  st_nxt = ST_SUS_WAIT;
            end
            ST_SUS_WAIT:
               if (cnt_hit_ddo)
                  st_nxt = ST_SUS_SKW;                                        // [R7]
            ST_SUS_SKW:
               if (cnt_hit_skip)
                  st_nxt = ST_SUS_SKIP;                                       // [R8]
         endcase
         // Every new wait counts its ticks from zero
         if (st_nxt != st_r)
            cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r  <= ST_RUN;
         cnt_r <= '0;
      end
      else if (clk_en)
      begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Disable drops once the wait expires; any exit raises it at once
   wire ddo_nxt  = !(st_nxt inside {ST_DS_SKW, ST_DS_SKIP, ST_SUS_SKW, ST_SUS_SKIP}); // [R2] [R4]
   wire skip_nxt = (st_nxt == ST_DS_SKIP) || (st_nxt == ST_SUS_SKIP);         // [R3] [R8]

   // Force window on deep-sleep edges, blank window on suspend edges
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         force_r     <= '0;
         blank_r     <= 1'b0;
         blank_cnt_r <= '0;
      end
      else if (clk_en)
      begin
         if (ds_fall || ds_rise)
            force_r <= DLY_BLANK;                                             // [R5]
         else if (tick && force_r != '0)
            force_r <= force_r - 6'h01;
         if (sus_rise || sus_fall)
         begin
            blank_r     <= 1'b1;                                              // [R10]
            blank_cnt_r <= '0;
         end
         else if (blank_r && at_tgt && tick)
         begin
            blank_cnt_r <= blank_cnt_r + 6'h01;
            if (blank_cnt_r == DLY_BLANK - 6'h01)
               blank_r <= 1'b0;                                               // [R10]
         end
      end
   end

   // Blanking only holds the good level up, it never invents one
   wire forcing = (force_r != '0);
   wire vg_nxt  = forcing | (blank_r ? (vg_r | pwr_good_raw) : pwr_good_raw);     // [R5] [R10]
   wire cg_nxt  = ~forcing & (blank_r ? (cg_r & clk_gate_raw_n) : clk_gate_raw_n); // [R5] [R10]

   // Gate-drive state; skip mode and interlocks decide transitions
   wire fire_ok = s2_r.err_low & ~s2_r.over_limit & s2_r.min_off_done;        // [R13] [R17]
   always_comb
   begin
      g_nxt = g_r;
      unique case (g_r)
         G_IDLE:
            if (!skip_mode && !fire_ok)
               g_nxt = G_LOW;                                                 // [R16]
            else if (fire_ok && s2_r.low_off_fb)
               g_nxt = G_HIGH;                                                // [R14]
         G_LOW:
            if (fire_ok || (skip_mode && s2_r.zero_cross))
               g_nxt = G_IDLE;                                                // [R12] [R14]
         G_HIGH:
            if (s2_r.on_time_done)
               g_nxt = G_DEAD;
         G_DEAD:
            if (dead_r == DEAD_CYC - 3'h1)
               g_nxt = G_LOW;                                                 // [R15]
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         g_r    <= G_IDLE;
         dead_r <= '0;
      end
      else if (clk_en)
      begin
         g_r    <= g_nxt;
         dead_r <= (g_r == G_DEAD) ? dead_r + 3'h1 : 3'h0;
      end
   end

   // All outputs registered so pins never glitch on decode
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         driver_disable_n <= 1'b1;
         skip_mode        <= 1'b0;
         vg_r             <= 1'b0;
         cg_r             <= 1'b1;
         gates            <= '0;
      end
      else if (clk_en)
      begin
         driver_disable_n <= ddo_nxt;
         skip_mode        <= skip_nxt;
         vg_r             <= vg_nxt;
         cg_r             <= cg_nxt;
         gates.high_gate  <= (g_nxt == G_HIGH);
         gates.low_gate   <= (g_nxt == G_LOW);
      end
   end
   assign vcore_good     = vg_r;
   assign cpu_clk_gate_n = cg_r;

   // Checks on the sequencer and gate interlocks
   chk_ddo_fall_time: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R2] [R7]
      $fell(driver_disable_n) && !$past(mode_edge) |-> $past(cnt_hit_ddo))
      else $error("driver disable fell without full delay");
   chk_skip_start: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R3] [R8]
      $rose(skip_mode) |-> $past(cnt_hit_skip) && !driver_disable_n)
      else $error("skip mode began early");
   chk_ds_exit: assert property (@(posedge clk_sys) disable iff (!arst_n)   // [R4]
      clk_en && ds_rise && !in_sus && !sus_rise |=> driver_disable_n && !skip_mode)
      else $error("deep-sleep exit did not restore drivers");
   chk_sus_exit: assert property (@(posedge clk_sys) disable iff (!arst_n)  // [R9]
      clk_en && sus_fall && s2_r.deep_sleep_n |=> driver_disable_n && st_r == ST_RUN)
      else $error("suspend exit did not restore drivers");
   chk_force_window: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R5]
      clk_en && forcing |=> vcore_good && !cpu_clk_gate_n)
      else $error("force window not honoured");
   chk_blank_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R10]
      clk_en && blank_r |=> !$fell(vcore_good) && !$rose(cpu_clk_gate_n))
      else $error("blanking let good fall or clock gate rise");
   chk_limit_block: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R13]
      $rose(gates.high_gate) |-> $past(s2_r.over_limit, 1) == 1'b0)
      else $error("cycle started over current limit");
   chk_dead_adapt: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R14]
      $rose(gates.high_gate) |-> $past(s2_r.low_off_fb) && !$past(gates.low_gate))
      else $error("high gate rose before low gate off");
   chk_dead_fixed: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R15]
      $fell(gates.high_gate) |-> !gates.low_gate [*5])
      else $error("low gate rose inside dead time");
   chk_zero_cross: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R12]
      clk_en && skip_mode && g_r == G_LOW && s2_r.zero_cross |=> !gates.low_gate)
      else $error("zero crossing did not end low gate");
   chk_no_overlap: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R16]
      !(gates.high_gate && gates.low_gate))
      else $error("both gates on");
   cov_ds_skip:  cover property (@(posedge clk_sys) st_r == ST_DS_SKIP);
   cov_sus_skip: cover property (@(posedge clk_sys) st_r == ST_SUS_SKIP);
   cov_pulse:    cover property (@(posedge clk_sys) $fell(gates.high_gate) ##[1:20] gates.low_gate);
endmodule : sleep_seq

// ---- slave_phase_model.sv ----
// Behavioural slave phase controller fed by the master's driver-disable line.
// Assumes the master's high-gate command is sampled on the same system clock.
`timescale 1ns/100ps
module slave_phase_model (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic driver_disable_n,
   input  wire logic pwm_cmd,
   output logic      slave_high,
   output logic      slave_low
);
   // Both gates parked low while disabled; complementary PWM otherwise
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         slave_high <= 1'b0;
         slave_low  <= 1'b0;
      end
      else
      begin
         slave_high <= driver_disable_n & pwm_cmd;
         slave_low  <= driver_disable_n & ~pwm_cmd;
      end
   end
endmodule : slave_phase_model

// ---- sleep_seq_bench.sv ----
// Self-checking bench for the sleep-mode sequencer and its gate timing.
// Assumes the package and the slave phase model are compiled first.
`timescale 1ns/100ps
module sleep_seq_bench;
   import sleep_seq_pkg::*;
   localparam int LIMIT = 10000;   // Cycles; the tests need about 2200
   logic            clk_sys;
   logic            arst_n;
   pins_t           pins;
   logic            pwr_good_raw;
   logic            clk_gate_raw_n;
   logic            driver_disable_n;
   logic            skip_mode;
   logic            vcore_good;
   logic            cpu_clk_gate_n;
   logic [SP_W-1:0] setpoint;
   gates_t          gates;
   logic            slave_high;
   logic            slave_low;
   logic [2:0]      tick_div;
   int              err_total;
   int              check_count;
   int              cyc;

   sleep_seq u_dut (
      .clk_sys          (clk_sys),
      .arst_n           (arst_n),
      .clk_en           (1'b1),
      .pins             (pins),
      .pwr_good_raw     (pwr_good_raw),
      .clk_gate_raw_n   (clk_gate_raw_n),
      .driver_disable_n (driver_disable_n),
      .skip_mode        (skip_mode),
      .vcore_good       (vcore_good),
      .cpu_clk_gate_n   (cpu_clk_gate_n),
      .setpoint         (setpoint),
      .gates            (gates)
   );

   slave_phase_model u_slave (
      .clk_sys          (clk_sys),
      .arst_n           (arst_n),
      .driver_disable_n (driver_disable_n),
      .pwm_cmd          (gates.high_gate),
      .slave_high       (slave_high),
      .slave_low        (slave_low)
   );

   always #4 clk_sys = ~clk_sys;

   // Rate clock: 4 high, 4 low, well above the two-cycle minimum
   always @(posedge clk_sys)
   begin
      tick_div <= tick_div + 3'h1;
      pins.slew_tick <= tick_div[2];
   end

   // Hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_total++;
         final_report();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Waits end 2 ns after an edge so the design's updates have landed
   task automatic ticks(input int n);
      repeat (n) @(posedge pins.slew_tick);
      #2;
   endtask : ticks

   task automatic clks(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : clks

   task automatic test_gates;
      int n;
      @(posedge clk_sys);
      pins.err_low      <= 1'b1;
      pins.over_limit   <= 1'b1;
      pins.min_off_done <= 1'b1;
      clks(20);
      check("high held by limit", gates.high_gate, 1'b0);
      @(posedge clk_sys);
      pins.over_limit <= 1'b0;
      clks(20);
      check("high waits low off", gates.high_gate, 1'b0);
      @(posedge clk_sys);
      pins.min_off_done <= 1'b0;
      pins.low_off_fb   <= 1'b1;
      clks(10);
      check("high waits off time", gates, 2'b01);
      @(posedge clk_sys);
      pins.min_off_done <= 1'b1;
      clks(10);
      check("high on", gates, 2'b10);
      @(posedge clk_sys);
      pins.on_time_done <= 1'b1;
      pins.err_low      <= 1'b0;
      pins.low_off_fb   <= 1'b0;
      n = 0;
      while (gates.high_gate !== 1'b0 && n < 20)
      begin
         clks(1);
         n++;
      end
      clks(4);
      check("dead time", gates.low_gate, 1'b0);
      clks(2);
      check("low after dead", gates, 2'b01);
      @(posedge clk_sys);
      pins.on_time_done <= 1'b0;
      $display("test_gates done");
   endtask : test_gates

   // Fall, rise, fall again: the delays count from the last fall only
   task automatic test_deep_sleep;
      @(posedge clk_sys);
      pins.deep_sleep_n <= 1'b0;
      ticks(20);
      @(posedge clk_sys);
      pins.deep_sleep_n <= 1'b1;
      ticks(1);
      @(posedge clk_sys);
      pins.deep_sleep_n <= 1'b0;
      ticks(32);
      check("disable at 32", driver_disable_n, 1'b1);
      check("good forced", vcore_good, 1'b1);
      check("clock forced", cpu_clk_gate_n, 1'b0);
      ticks(1);
      check("disable at 33", driver_disable_n, 1'b0);
      check("force over", vcore_good, 1'b0);
      check("slave parked", {slave_high, slave_low}, 2'b00);
      ticks(29);
      check("skip early", skip_mode, 1'b0);
      ticks(1);
      check("skip on", skip_mode, 1'b1);
      check("offset added", setpoint, 8'h22);
      // One pulse in skip mode: the zero crossing must end the low gate
      @(posedge clk_sys);
      pins.err_low    <= 1'b1;
      pins.low_off_fb <= 1'b1;
      clks(8);
      check("skip high on", gates, 2'b10);
      check("slave parked on pulse", {slave_high, slave_low}, 2'b00);
      @(posedge clk_sys);
      pins.on_time_done <= 1'b1;
      pins.err_low      <= 1'b0;
      pins.low_off_fb   <= 1'b0;
      clks(12);
      check("skip low after dead", gates, 2'b01);
      @(posedge clk_sys);
      pins.zero_cross <= 1'b1;
      clks(6);
      check("zero cross ends low", gates, 2'b00);
      @(posedge clk_sys);
      pins.deep_sleep_n <= 1'b1;
      pins.zero_cross   <= 1'b0;
      pins.on_time_done <= 1'b0;
      clks(5);
      check("drivers back", driver_disable_n, 1'b1);
      check("pwm low back", gates, 2'b01);
      check("pwm back", skip_mode, 1'b0);
      check("good forced exit", vcore_good, 1'b1);
      ticks(40);
      check("offset removed", setpoint, 8'h20);
      $display("test_deep_sleep done");
   endtask : test_deep_sleep

   task automatic test_suspend;
      int n;
      @(posedge clk_sys);
      pwr_good_raw   <= 1'b1;
      clk_gate_raw_n <= 1'b0;
      clks(4);
      @(posedge clk_sys);
      pins.suspend_req <= 1'b1;
      repeat (6) @(posedge clk_sys);
      pwr_good_raw   <= 1'b0;
      clk_gate_raw_n <= 1'b1;
      n = 0;
      while (setpoint !== 8'h13 && n < 400)
      begin
         clks(1);
         n++;
      end
      check("suspend target", setpoint, 8'h13);
      ticks(32);
      check("disable waits", driver_disable_n, 1'b1);
      check("good blanked", vcore_good, 1'b1);
      check("clock blanked", cpu_clk_gate_n, 1'b0);
      ticks(1);
      check("disable low", driver_disable_n, 1'b0);
      check("blank over", vcore_good, 1'b0);
      check("clock unblanked", cpu_clk_gate_n, 1'b1);
      ticks(29);
      check("skip waits", skip_mode, 1'b0);
      ticks(1);
      check("skip on", skip_mode, 1'b1);
      @(posedge clk_sys);
      pins.suspend_req <= 1'b0;
      clks(5);
      check("drivers back", driver_disable_n, 1'b1);
      check("pwm back", skip_mode, 1'b0);
      ticks(20);
      check("vid restored", setpoint, 8'h20);
      $display("test_suspend done");
   endtask : test_suspend

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   // Deep sleep is held inactive through reset so no false edge is seen
   initial
   begin
      clk_sys        = 1'b0;
      arst_n         = 1'b0;
      pins           = '0;
      pins.deep_sleep_n = 1'b1;
      pins.vid_code     = 6'h20;
      pins.suspend_code = 3'h3;
      pins.offset_plus  = 4'h3;
      pins.offset_minus = 4'h1;
      pwr_good_raw   = 1'b0;
      clk_gate_raw_n = 1'b1;
      tick_div       = 3'h0;
      err_total      = 0;
      check_count    = 0;
      cyc            = 0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      ticks(40);
      test_gates();
      test_deep_sleep();
      test_suspend();
      final_report();
   end
endmodule : sleep_seq_bench
